/* core/lbc_bus_interface_unit.sv */
// local bus controller with divide-by-two clock generator and powerdown
`timescale 1ns/100ps
`default_nettype none
`include "lbc_defs.svh"
module lbc_bus_interface_unit #(
  parameter int ADDR_W = `LBC_ADDR_W,
  parameter int DATA_W = `LBC_DATA_W
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_powerdown,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  output logic                   o_req_ready,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  input  wire logic              i_sync_ready_in,
  input  wire logic              i_async_ready_in,
  input  wire logic              i_hold_request,
  output logic                   o_bus_share_grant,
  output logic [ADDR_W-1:0]      o_ad_out,
  output logic                   o_ad_oe,
  input  wire logic [DATA_W-1:0] i_ad_in,
  output logic                   o_rd_strobe_n,
  output logic                   o_wr_strobe_n,
  output logic [2:0]             o_status,
  output logic                   o_ctl_oe,
  output logic                   o_transceiver_data_enable_n,
  output logic                   o_processor_clock_out,
  output logic                   o_phase
);
  lbc_pkg::lbc_state_t state;
  logic                phase;
  logic                clk_out;
  logic                cyc_write;
  logic [ADDR_W-1:0]   cyc_addr;
  logic [DATA_W-1:0]   cyc_wdata;
  logic                ready_any;
  logic                step;

  // status code that the bus shows for a read or a write cycle
  function automatic logic [2:0] cycle_status(input logic wr);
    return wr ? `LBC_STAT_WRITE : `LBC_STAT_READ;
  endfunction

  assign ready_any = i_sync_ready_in | i_async_ready_in;
  // one processor state every second input clock, frozen in powerdown
  assign step      = phase & ~i_powerdown;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase   <= 1'b0;
      clk_out <= 1'b0;
    end else if (!i_powerdown) begin
      phase   <= ~phase;
      clk_out <= ~phase;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= lbc_pkg::LBC_IDLE;
    end else if (step) begin
      case (state)
        lbc_pkg::LBC_IDLE: begin
          if (i_hold_request) begin
            state <= lbc_pkg::LBC_HOLD;
          end else if (i_req_valid) begin
            state <= lbc_pkg::LBC_T1;
          end
        end
        lbc_pkg::LBC_T1: state <= lbc_pkg::LBC_T2;
        lbc_pkg::LBC_T2: state <= lbc_pkg::LBC_T3;
        lbc_pkg::LBC_T3: begin
          if (ready_any) begin
            state <= lbc_pkg::LBC_T4;
          end
        end
        lbc_pkg::LBC_T4: state <= lbc_pkg::LBC_IDLE;
        lbc_pkg::LBC_HOLD: begin
          if (!i_hold_request) begin
            state <= lbc_pkg::LBC_IDLE;
          end
        end
        default: state <= lbc_pkg::LBC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_write <= 1'b0;
      cyc_addr  <= '0;
      cyc_wdata <= '0;
    end else if (o_req_ready && i_req_valid) begin
      cyc_write <= i_req_write;
      cyc_addr  <= i_req_addr;
      cyc_wdata <= i_req_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      o_rd_valid <= 1'b0;
      if (step && state == lbc_pkg::LBC_T3 && ready_any && !cyc_write) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= i_ad_in;
      end
    end
  end

  assign o_req_ready = step && state == lbc_pkg::LBC_IDLE && !i_hold_request;
  assign o_bus_share_grant = state == lbc_pkg::LBC_HOLD;
  assign o_processor_clock_out = clk_out;
  assign o_phase = phase;

  always_comb begin
    o_ad_out = cyc_addr;
    o_ad_oe  = 1'b0;
    o_rd_strobe_n = 1'b1;
    o_wr_strobe_n = 1'b1;
    o_status = `LBC_STAT_IDLE;
    o_transceiver_data_enable_n = 1'b1;
    case (state)
      lbc_pkg::LBC_T1: begin
        o_ad_oe  = 1'b1;
        o_status = cycle_status(cyc_write);
      end
      lbc_pkg::LBC_T2, lbc_pkg::LBC_T3: begin
        o_status = cycle_status(cyc_write);
        o_transceiver_data_enable_n = 1'b0;
        if (cyc_write) begin
          o_ad_out      = {{(ADDR_W-DATA_W){1'b0}}, cyc_wdata};
          o_ad_oe       = 1'b1;
          o_wr_strobe_n = 1'b0;
        end else begin
          o_rd_strobe_n = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  assign o_ctl_oe = state != lbc_pkg::LBC_HOLD;

  // a bus cycle has just entered its address state
  sequence seq_cycle_start;
    $rose(state == lbc_pkg::LBC_T1);
  endsequence
  // no read answer through the first three states, six input clocks
  sequence seq_no_early_answer;
    !o_rd_valid [*6];
  endsequence
  // a processor step that samples the ready inputs
  sequence seq_ready_sample;
    step && state == lbc_pkg::LBC_T3;
  endsequence
  // one high input clock of clock out, then one low
  sequence seq_clock_high_low;
    o_processor_clock_out ##1 !o_processor_clock_out;
  endsequence

  chk_hold_floats_bus: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_bus_share_grant |-> (!o_ad_oe && !o_ctl_oe))
    else $error("bus driven during hold");
  chk_grant_needs_req: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_bus_share_grant) |-> $past(i_hold_request))
    else $error("grant without request");
  chk_grant_release: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_bus_share_grant) |-> !$past(i_hold_request))
    else $error("bus taken back while hold requested");
  chk_clock_halves: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rst_n) && !i_powerdown && !$past(i_powerdown) |-> clk_out != $past(clk_out))
    else $error("clock out not toggling");
  chk_clock_duty: assert property (@(posedge i_clock)
    disable iff (!i_rst_n || i_powerdown)
    $rose(o_processor_clock_out) |-> seq_clock_high_low)
    else $error("clock out duty not even");
  chk_powerdown_frozen: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_powerdown) |-> $stable(phase) && $stable(state))
    else $error("state moved in powerdown");
  chk_phase_steps: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !$past(phase) |-> $stable(state))
    else $error("state moved at wrong phase");
  chk_min_states: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    seq_cycle_start |-> seq_no_early_answer)
    else $error("cycle shorter than four states");
  chk_ready_ends: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    seq_ready_sample ##0 ready_any |=> state == lbc_pkg::LBC_T4)
    else $error("ready did not end the cycle");
  chk_ready_waits: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    seq_ready_sample ##0 !ready_any |=> state == lbc_pkg::LBC_T3)
    else $error("cycle ended without ready");
  chk_den_data: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_transceiver_data_enable_n |-> (!o_rd_strobe_n || !o_wr_strobe_n))
    else $error("enable outside data portion");
  chk_addr_phase: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == lbc_pkg::LBC_T1 |-> o_ad_oe && o_transceiver_data_enable_n && o_ad_out == cyc_addr)
    else $error("address state wrong");
  chk_rd_capture: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rd_valid |-> !cyc_write && o_rd_data == $past(i_ad_in))
    else $error("read data not captured");
  chk_wr_status: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_wr_strobe_n |-> o_status == `LBC_STAT_WRITE && o_ad_oe)
    else $error("write without status or data");
  chk_rd_status: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_rd_strobe_n |-> o_status == `LBC_STAT_READ && !o_ad_oe)
    else $error("read without status or with bus driven");
endmodule // lbc_bus_interface_unit
`default_nettype wire

/* core/lbc_defs.svh */
// constants for the local bus interface and clock divider
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
`define LBC_ADDR_W      20
`define LBC_DATA_W      16
`define LBC_STAT_W      3
`define LBC_MIN_STATES  4
`define LBC_STAT_IDLE   3'h7
`define LBC_STAT_READ   3'h5
`define LBC_STAT_WRITE  3'h6
`endif

/* core/lbc_pkg.sv */
// types for the local bus interface and clock divider
`default_nettype none
package lbc_pkg;
  typedef enum logic [2:0] {
    LBC_IDLE  = 3'h0,
    LBC_T1    = 3'h1,
    LBC_T2    = 3'h3,
    LBC_T3    = 3'h2,
    LBC_T4    = 3'h6,
    LBC_HOLD  = 3'h4
  } lbc_state_t;
endpackage
`default_nettype wire

/* verif/lbc_bus_interface_unit_tb_top.sv */
// self-checking bench for the local bus interface
`timescale 1ns/100ps
`default_nettype none
`include "lbc_defs.svh"
module lbc_bus_interface_unit_tb_top;
  logic i_clock = 0, i_rst_n = 0, i_powerdown = 0, i_req_valid = 0, i_req_write = 0;
  logic i_hold_request = 0, i_sync_ready_in, o_req_ready, o_rd_valid, o_bus_share_grant, o_ad_oe;
  logic use_async = 0, i_async_ready_in;
  logic o_rd_strobe_n, o_wr_strobe_n, o_ctl_oe, o_transceiver_data_enable_n;
  logic o_processor_clock_out, o_phase;
  logic [19:0] i_req_addr = 20'h0, o_ad_out;
  logic [15:0] i_req_wdata = 16'h0, i_ad_in, o_rd_data, rdata = 16'h0;
  logic [3:0] waits = 4'h0;
  logic [2:0] o_status;
  int failures = 0, n_tests = 0, cyc = 0;
  lbc_bus_interface_unit dut (.i_clock, .i_rst_n, .i_powerdown, .i_req_valid, .i_req_write,
    .i_req_addr, .i_req_wdata, .o_req_ready, .o_rd_valid, .o_rd_data, .i_sync_ready_in,
    .i_async_ready_in, .i_hold_request, .o_bus_share_grant, .o_ad_out, .o_ad_oe, .i_ad_in,
    .o_rd_strobe_n, .o_wr_strobe_n, .o_status, .o_ctl_oe, .o_transceiver_data_enable_n,
    .o_processor_clock_out, .o_phase);
  lbc_mem_model mem (.i_clock, .i_strobe_n(o_rd_strobe_n & o_wr_strobe_n),
    .i_rd_strobe_n(o_rd_strobe_n), .i_waits(waits), .i_rdata(rdata), .i_async_sel(use_async),
    .o_ad_in(i_ad_in), .o_ready(i_sync_ready_in), .o_async_ready(i_async_ready_in));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #10;
  endtask
  task automatic clock_test();
    int hi = 0;
    logic prev;
    prev = o_processor_clock_out;
    for (int k = 0; k < 8; k++) begin
      tick(1);
      chk(o_processor_clock_out, !prev);
      prev = o_processor_clock_out;
      hi += o_processor_clock_out;
    end
    chk(hi, 4);
  endtask
  task automatic bus_cycle(input logic wr, input logic [19:0] a, input logic [15:0] d, input int w);
    int n = 0;
    waits = 4'(w);
    rdata = d;
    i_req_write = wr;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_valid = 1;
    while (o_req_ready !== 1'b1 && n < 50) begin tick(1); n++; end
    chk(o_phase, 1'b1);
    tick(1);
    i_req_valid = 0;
    n = 1;
    while (o_status === `LBC_STAT_IDLE && n < 10) begin tick(1); n++; end
    chk(o_status, wr ? `LBC_STAT_WRITE : `LBC_STAT_READ);
    chk({o_ad_oe, o_ad_out}, {1'b1, a});
    while ((o_rd_strobe_n & o_wr_strobe_n) !== 1'b0 && n < 20) begin tick(1); n++; end
    chk({o_rd_strobe_n, o_wr_strobe_n, o_transceiver_data_enable_n}, {wr, !wr, 1'b0});
    if (wr) chk({o_ad_oe, o_ad_out}, {1'b1, 4'h0, d});
    else chk(o_ad_oe, 1'b0);
    while ((o_rd_strobe_n & o_wr_strobe_n) !== 1'b1 && n < 60) begin tick(1); n++; end
    chk(n, 7 + 2 * w);
    chk({o_rd_valid, o_transceiver_data_enable_n}, {!wr, 1'b1});
    if (!wr) chk(o_rd_data, d);
    tick(6);
  endtask
  task automatic hold_test();
    int n = 0;
    i_hold_request = 1;
    while (o_bus_share_grant !== 1'b1 && n < 20) begin tick(1); n++; end
    chk({o_bus_share_grant, o_ad_oe, o_ctl_oe}, 3'h4);
    i_req_valid = 1;
    tick(4);
    chk({o_req_ready, o_bus_share_grant}, 2'h1);
    i_req_valid = 0;
    i_hold_request = 0;
    tick(6);
    chk({o_bus_share_grant, o_ctl_oe}, 2'h1);
  endtask
  task automatic powerdown_test();
    logic s;
    i_powerdown = 1;
    tick(2);
    s = o_processor_clock_out;
    tick(5);
    chk(o_processor_clock_out, s);
    chk(o_req_ready, 1'b0);
    i_powerdown = 0;
    tick(2);
  endtask
  initial begin
    tick(16);
    chk({o_rd_strobe_n, o_wr_strobe_n, o_processor_clock_out}, 3'h6);
    i_rst_n = 1;
    clock_test();
    bus_cycle(1, 20'hfedcb, 16'h1234, 0);
    bus_cycle(0, 20'h0a5a5, 16'hc3e1, 0);
    bus_cycle(0, 20'h12345, 16'h8001, 3);
    use_async = 1;
    bus_cycle(0, 20'h5a5a5, 16'h7e81, 2);
    bus_cycle(1, 20'h0f0f0, 16'h55aa, 1);
    use_async = 0;
    hold_test();
    powerdown_test();
    clock_test();
    summarize();
  end
endmodule // lbc_bus_interface_unit_tb_top
`default_nettype wire

/* verif/lbc_mem_model.sv */
// memory-side partner that answers local bus cycles
`timescale 1ns/100ps
`default_nettype none
module lbc_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_strobe_n,
  input  wire logic        i_rd_strobe_n,
  input  wire logic [3:0]  i_waits,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_async_sel,
  output logic [15:0]      o_ad_in,
  output logic             o_ready,
  output logic             o_async_ready
);
  logic [4:0] cnt;
  logic       ready;
  always_ff @(posedge i_clock) begin
    cnt <= i_strobe_n ? 5'h0 : cnt + 5'h1;
  end
  // ready held off for the asked number of wait states, on the chosen line
  assign ready         = !i_strobe_n && (cnt >= {i_waits, 1'b0} + 5'h2);
  assign o_ready       = ready & ~i_async_sel;
  assign o_async_ready = ready & i_async_sel;
  // released bus shows the inverse of the word
  assign o_ad_in = i_rd_strobe_n ? ~i_rdata : i_rdata;
endmodule // lbc_mem_model
`default_nettype wire
